// *** common/clock_detector_pkg.sv ***
package clock_detector_pkg;

  // Status register location and layout.
  localparam logic [7:0] STATUS_ADDR = 8'h5e;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int unsigned BIT_MCLK_MISSING = 6;
  localparam int unsigned BIT_PLL_LOCKED = 5;
  localparam int unsigned BIT_LINK_MISSING = 4;
  localparam int unsigned BIT_AUTOSET_BAD = 3;
  localparam int unsigned BIT_MCLK_BAD = 2;
  localparam int unsigned BIT_SCLK_BAD = 1;
  localparam int unsigned BIT_RATE_BAD = 0;
  localparam int unsigned STATUS_W = 8;

  // Counter width shared by every measuring counter.
  localparam int unsigned CNT_W = 13;
  typedef logic [CNT_W-1:0] cnt_t;
  localparam cnt_t CNT_ZERO = 13'h0000;
  localparam cnt_t CNT_ONE = 13'h0001;
  localparam cnt_t CNT_MAX = 13'h1fff;

  // System clock and the time after which a silent clock is missing.
  localparam int unsigned CLK_SYS_HZ = 25_000_000;
  localparam int unsigned MISSING_TIME_US = 100;
  localparam cnt_t MISSING_CYC =
    CNT_W'(CLK_SYS_HZ / 1_000_000 * MISSING_TIME_US);

  // Accepted sample rate window, as frame periods in system cycles.
  localparam int unsigned FS_MIN_HZ = 8000;
  localparam int unsigned FS_MAX_HZ = 192000;
  localparam cnt_t FRAME_CYC_MAX = CNT_W'(CLK_SYS_HZ / FS_MIN_HZ);
  localparam cnt_t FRAME_CYC_MIN =
    CNT_W'((CLK_SYS_HZ + FS_MAX_HZ - 1) / FS_MAX_HZ);

  // Bit clock limits per frame and the short frame-low limit.
  localparam cnt_t SCLK_RATIO_MIN = 13'h0020;
  localparam cnt_t SCLK_RATIO_MAX = 13'h0100;
  localparam cnt_t FS_LOW_MIN_SCLK = 13'h0005;

  // Link heartbeat: last count of the beat counter; one toggle every eight bit clocks.
  localparam logic [2:0] HEARTBEAT_LAST = 3'h7;

  // Master clock ratio codes; code 0 marks a ratio that is not allowed.
  localparam logic [3:0] RATIO_ERR = 4'h0;
  localparam logic [3:0] RATIO_NO_PLL_MIN = 4'h4;
  localparam int unsigned RATIO_NUM = 14;
  localparam cnt_t RATIO_TABLE [RATIO_NUM] = '{
    13'h0020, 13'h0030, 13'h0040, 13'h0080, 13'h00c0, 13'h0100, 13'h0180,
    13'h0200, 13'h0300, 13'h0400, 13'h0480, 13'h0600, 13'h0800, 13'h0c00
  };

  // One frame as measured on the link side.
  typedef struct packed {
    cnt_t bits_per_frame;
    cnt_t low_len;
    logic stable;
  } frame_meas_s;

  // Counter step that sticks at the top instead of wrapping.
  function automatic cnt_t sat_inc(input cnt_t value);
    return (value == CNT_MAX) ? value : value + CNT_ONE;
  endfunction : sat_inc

  // Maps a master clock count per frame to its ratio code.
  // A tolerance of one edge absorbs the crossing jitter of the frame mark.
  function automatic logic [3:0] ratio_code(input cnt_t count);
    logic [3:0] code;
    code = RATIO_ERR;
    for (int i = 0; i < RATIO_NUM; i++) begin
      if ((count + CNT_ONE >= RATIO_TABLE[i]) &&
          (count <= RATIO_TABLE[i] + CNT_ONE)) begin
        code = 4'(i + 1);
      end
    end
    return code;
  endfunction : ratio_code

endpackage : clock_detector_pkg

// *** verilog/frame_meter.sv ***
`timescale 1ns/10ps
module frame_meter (
  input wire logic clk_link,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic frame_sync_clock,
  output clock_detector_pkg::frame_meas_s meas,
  output logic meas_toggle,
  output logic heartbeat
);

  logic en_s1;
  logic en_s2;
  logic fs_q;
  clock_detector_pkg::cnt_t bit_cnt;
  clock_detector_pkg::cnt_t low_cnt;
  logic [2:0] beat_cnt;
  clock_detector_pkg::frame_meas_s next_meas;
  logic next_meas_toggle;
  logic next_heartbeat;
  logic next_fs_q;
  clock_detector_pkg::cnt_t next_bit_cnt;
  clock_detector_pkg::cnt_t next_low_cnt;
  logic [2:0] next_beat_cnt;
  clock_detector_pkg::cnt_t frame_bits;

  // The enable comes from the system domain, so it is synchronised here.
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      en_s1 <= 1'b0;
      en_s2 <= 1'b0;
    end else begin
      en_s1 <= clk_en;
      en_s2 <= en_s1;
    end
  end

  // Frame sync is launched on this clock, so it is used without a chain.
  // A frame ends on each rising edge; the word is held for a whole frame,
  // which lets the other domain take it on the toggle alone.
  always_comb begin
    frame_bits = clock_detector_pkg::sat_inc(bit_cnt);
    next_meas = meas;
    next_meas_toggle = meas_toggle;
    next_heartbeat = heartbeat;
    next_fs_q = fs_q;
    next_bit_cnt = bit_cnt;
    next_low_cnt = low_cnt;
    next_beat_cnt = beat_cnt;
    if (en_s2) begin
      next_fs_q = frame_sync_clock;
      next_beat_cnt = beat_cnt + 3'h1;
      if (beat_cnt == clock_detector_pkg::HEARTBEAT_LAST) begin
        next_heartbeat = ~heartbeat;
      end
      if (frame_sync_clock && !fs_q) begin
        next_meas.bits_per_frame = frame_bits;
        next_meas.stable = (frame_bits == meas.bits_per_frame); // see [RULE7]
        next_meas.low_len = low_cnt; // see [RULE6]
        next_meas_toggle = ~meas_toggle;
        next_bit_cnt = clock_detector_pkg::CNT_ZERO;
        next_low_cnt = clock_detector_pkg::CNT_ZERO;
      end else begin
        next_bit_cnt = frame_bits;
        if (!frame_sync_clock) begin
          next_low_cnt = clock_detector_pkg::sat_inc(low_cnt);
        end
      end
    end
  end

  // Link state registers.
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      meas <= '0;
      meas_toggle <= 1'b0;
      heartbeat <= 1'b0;
      fs_q <= 1'b0;
      bit_cnt <= clock_detector_pkg::CNT_ZERO;
      low_cnt <= clock_detector_pkg::CNT_ZERO;
      beat_cnt <= 3'h0;
    end else begin
      meas <= next_meas;
      meas_toggle <= next_meas_toggle;
      heartbeat <= next_heartbeat;
      fs_q <= next_fs_q;
      bit_cnt <= next_bit_cnt;
      low_cnt <= next_low_cnt;
      beat_cnt <= next_beat_cnt;
    end
  end

endmodule : frame_meter

// *** verilog/clock_detector.sv ***
// Function
// [RULE1] Bit 6 reads 1 when the master clock is halted, else 0.
// [RULE2] Bit 5 reads 1 when the PLL is locked; disabled reads unlocked.
// [RULE3] Bit 4 reads 1 only when frame and bit clocks are both missing.
// [RULE4] Bit 3 reads 1 when rate and ratio cannot be auto set.
// [RULE5] Bit 2 reads 1 when the master clock ratio is undetectable.
// [RULE6] Bit 2 also reads 1 when frame low lasts five bit clocks or less.
// [RULE7] Bit 1 reads 1 unless bits per frame are stable within 32 to 256.
// [RULE8] Bit 0 reads 1 when the sample rate cannot be detected.
// [RULE9] Bit 0 is dropped while the error-ignore setting is active.
// [RULE10] Only the fourteen listed ratios are detectable; code 0 is error.
// [RULE11] Flags are live, writes do nothing, bit 7 reads zero.
`timescale 1ns/10ps
module clock_detector (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic clk_link,
  input wire logic frame_sync_clock,
  input wire logic master_clock,
  input wire logic pll_enable,
  input wire logic pll_lock,
  input wire logic error_ignore_config,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  output logic [7:0] reg_rdata,
  output logic reg_ack
);

  // Link side measurements and the crossings that carry them.
  clock_detector_pkg::frame_meas_s link_meas;
  logic link_toggle;
  logic link_beat;
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic beat_s1;
  logic beat_s2;
  logic beat_s3;
  logic fs_s1;
  logic fs_s2;
  logic fs_s3;
  logic mclk_s1;
  logic mclk_s2;
  logic mclk_s3;
  logic lock_s1;
  logic lock_s2;
  logic frame_event;
  logic next_tog_s1;
  logic next_tog_s2;
  logic next_tog_s3;
  logic next_beat_s1;
  logic next_beat_s2;
  logic next_beat_s3;
  logic next_fs_s1;
  logic next_fs_s2;
  logic next_fs_s3;
  logic next_mclk_s1;
  logic next_mclk_s2;
  logic next_mclk_s3;
  logic next_lock_s1;
  logic next_lock_s2;

  // Activity timers and per-frame counters.
  clock_detector_pkg::cnt_t mclk_idle;
  clock_detector_pkg::cnt_t sclk_idle;
  clock_detector_pkg::cnt_t fs_idle;
  clock_detector_pkg::cnt_t cyc_cnt;
  clock_detector_pkg::cnt_t mclk_cnt;
  clock_detector_pkg::cnt_t frame_cyc;
  clock_detector_pkg::cnt_t mclk_per_frame;
  clock_detector_pkg::frame_meas_s meas_q;
  clock_detector_pkg::cnt_t next_mclk_idle;
  clock_detector_pkg::cnt_t next_sclk_idle;
  clock_detector_pkg::cnt_t next_fs_idle;
  clock_detector_pkg::cnt_t next_cyc_cnt;
  clock_detector_pkg::cnt_t next_mclk_cnt;
  clock_detector_pkg::cnt_t next_frame_cyc;
  clock_detector_pkg::cnt_t next_mclk_per_frame;
  clock_detector_pkg::frame_meas_s next_meas_q;

  // Status and register port state.
  logic [7:0] status;
  logic [7:0] next_status;
  logic [7:0] next_reg_rdata;
  logic next_reg_ack;
  logic mclk_missing;
  logic sclk_missing;
  logic fs_missing;
  logic rate_bad;
  logic [3:0] ratio;

  // Bit clock side of the detector; it runs on the audio bit clock.
  frame_meter frame_meter_i (
    .clk_link(clk_link),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .frame_sync_clock(frame_sync_clock),
    .meas(link_meas),
    .meas_toggle(link_toggle),
    .heartbeat(link_beat)
  );

  // Every foreign level passes two flops; the third flop of some chains
  // exists only for edge detection, so the first stays private.
  // A low enable holds every stage, so no edge is lost while frozen.
  always_comb begin
    next_tog_s1 = tog_s1;
    next_tog_s2 = tog_s2;
    next_tog_s3 = tog_s3;
    next_beat_s1 = beat_s1;
    next_beat_s2 = beat_s2;
    next_beat_s3 = beat_s3;
    next_fs_s1 = fs_s1;
    next_fs_s2 = fs_s2;
    next_fs_s3 = fs_s3;
    next_mclk_s1 = mclk_s1;
    next_mclk_s2 = mclk_s2;
    next_mclk_s3 = mclk_s3;
    next_lock_s1 = lock_s1;
    next_lock_s2 = lock_s2;
    if (clk_en) begin
      next_tog_s1 = link_toggle;
      next_tog_s2 = tog_s1;
      next_tog_s3 = tog_s2;
      next_beat_s1 = link_beat;
      next_beat_s2 = beat_s1;
      next_beat_s3 = beat_s2;
      next_fs_s1 = frame_sync_clock;
      next_fs_s2 = fs_s1;
      next_fs_s3 = fs_s2;
      next_mclk_s1 = master_clock;
      next_mclk_s2 = mclk_s1;
      next_mclk_s3 = mclk_s2;
      next_lock_s1 = pll_lock;
      next_lock_s2 = lock_s1;
    end
  end

  // Crossing registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      beat_s1 <= 1'b0;
      beat_s2 <= 1'b0;
      beat_s3 <= 1'b0;
      fs_s1 <= 1'b0;
      fs_s2 <= 1'b0;
      fs_s3 <= 1'b0;
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
    end else begin
      tog_s1 <= next_tog_s1;
      tog_s2 <= next_tog_s2;
      tog_s3 <= next_tog_s3;
      beat_s1 <= next_beat_s1;
      beat_s2 <= next_beat_s2;
      beat_s3 <= next_beat_s3;
      fs_s1 <= next_fs_s1;
      fs_s2 <= next_fs_s2;
      fs_s3 <= next_fs_s3;
      mclk_s1 <= next_mclk_s1;
      mclk_s2 <= next_mclk_s2;
      mclk_s3 <= next_mclk_s3;
      lock_s1 <= next_lock_s1;
      lock_s2 <= next_lock_s2;
    end
  end

  assign frame_event = tog_s2 ^ tog_s3;

  // Idle timers restart on a master clock rising edge, a heartbeat toggle or any frame clock change, and stick at the missing limit.
  // The master clock is sampled, so it must run below half of clk_sys
  // for its count to be exact; faster clocks read as a ratio error.
  // The frame word is taken on the toggle edge: it was written together
  // with the toggle on the link side and is held there for a whole frame.
  always_comb begin
    next_mclk_idle = mclk_idle;
    next_sclk_idle = sclk_idle;
    next_fs_idle = fs_idle;
    next_cyc_cnt = cyc_cnt;
    next_mclk_cnt = mclk_cnt;
    next_frame_cyc = frame_cyc;
    next_mclk_per_frame = mclk_per_frame;
    next_meas_q = meas_q;
    if (clk_en) begin
      if (mclk_s2 && !mclk_s3) begin
        next_mclk_idle = clock_detector_pkg::CNT_ZERO;
      end else if (mclk_idle != clock_detector_pkg::MISSING_CYC) begin
        next_mclk_idle = clock_detector_pkg::sat_inc(mclk_idle); // see [RULE1]
      end
      if (beat_s2 != beat_s3) begin
        next_sclk_idle = clock_detector_pkg::CNT_ZERO;
      end else if (sclk_idle != clock_detector_pkg::MISSING_CYC) begin
        next_sclk_idle = clock_detector_pkg::sat_inc(sclk_idle);
      end
      if (fs_s2 != fs_s3) begin
        next_fs_idle = clock_detector_pkg::CNT_ZERO;
      end else if (fs_idle != clock_detector_pkg::MISSING_CYC) begin
        next_fs_idle = clock_detector_pkg::sat_inc(fs_idle);
      end
      next_mclk_cnt = (mclk_s2 && !mclk_s3) ?
        clock_detector_pkg::sat_inc(mclk_cnt) : mclk_cnt;
      next_cyc_cnt = clock_detector_pkg::sat_inc(cyc_cnt);
      if (frame_event) begin
        next_frame_cyc = next_cyc_cnt; // see [RULE8]
        next_mclk_per_frame = next_mclk_cnt; // see [RULE5]
        next_meas_q = link_meas;
        next_cyc_cnt = clock_detector_pkg::CNT_ZERO;
        next_mclk_cnt = clock_detector_pkg::CNT_ZERO;
      end
    end
  end

  // Measurement registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mclk_idle <= clock_detector_pkg::CNT_ZERO;
      sclk_idle <= clock_detector_pkg::CNT_ZERO;
      fs_idle <= clock_detector_pkg::CNT_ZERO;
      cyc_cnt <= clock_detector_pkg::CNT_ZERO;
      mclk_cnt <= clock_detector_pkg::CNT_ZERO;
      frame_cyc <= clock_detector_pkg::CNT_ZERO;
      mclk_per_frame <= clock_detector_pkg::CNT_ZERO;
      meas_q <= '0;
    end else begin
      mclk_idle <= next_mclk_idle;
      sclk_idle <= next_sclk_idle;
      fs_idle <= next_fs_idle;
      cyc_cnt <= next_cyc_cnt;
      mclk_cnt <= next_mclk_cnt;
      frame_cyc <= next_frame_cyc;
      mclk_per_frame <= next_mclk_per_frame;
      meas_q <= next_meas_q;
    end
  end

  // Flags are recomputed every enabled cycle and never latched; a missing link
  // leaves stale frame words behind; missing clocks override them in bits 0, 1 and 3 but not in bit 2.
  always_comb begin
    mclk_missing = (mclk_idle == clock_detector_pkg::MISSING_CYC);
    sclk_missing = (sclk_idle == clock_detector_pkg::MISSING_CYC);
    fs_missing = (fs_idle == clock_detector_pkg::MISSING_CYC);
    ratio = clock_detector_pkg::ratio_code(mclk_per_frame); // see [RULE10]
    rate_bad = fs_missing || sclk_missing ||
      (frame_cyc < clock_detector_pkg::FRAME_CYC_MIN) ||
      (frame_cyc > clock_detector_pkg::FRAME_CYC_MAX); // see [RULE8]
    next_status = clock_detector_pkg::STATUS_RESET; // see [RULE11]
    next_status[clock_detector_pkg::BIT_MCLK_MISSING] =
      mclk_missing; // see [RULE1]
    next_status[clock_detector_pkg::BIT_PLL_LOCKED] =
      pll_enable && lock_s2; // see [RULE2]
    next_status[clock_detector_pkg::BIT_LINK_MISSING] =
      fs_missing && sclk_missing; // see [RULE3]
    next_status[clock_detector_pkg::BIT_AUTOSET_BAD] = rate_bad ||
      (ratio == clock_detector_pkg::RATIO_ERR) ||
      (!pll_enable &&
       (ratio < clock_detector_pkg::RATIO_NO_PLL_MIN)); // see [RULE4]
    next_status[clock_detector_pkg::BIT_MCLK_BAD] = mclk_missing ||
      (ratio == clock_detector_pkg::RATIO_ERR) || // see [RULE5]
      (meas_q.low_len <= clock_detector_pkg::FS_LOW_MIN_SCLK); // see [RULE6]
    next_status[clock_detector_pkg::BIT_SCLK_BAD] = sclk_missing ||
      fs_missing || !meas_q.stable ||
      (meas_q.bits_per_frame < clock_detector_pkg::SCLK_RATIO_MIN) ||
      (meas_q.bits_per_frame > clock_detector_pkg::SCLK_RATIO_MAX); // see [RULE7]
    // The ignore setting hides only the rate flag; the others stay honest.
    next_status[clock_detector_pkg::BIT_RATE_BAD] =
      rate_bad && !error_ignore_config; // see [RULE9]
    if (!clk_en) begin
      next_status = status;
    end
  end

  // Register port: a read of STATUS_ADDR returns the status word one cycle
  // later, other addresses zero; a write is acknowledged the same way but changes nothing.
  always_comb begin
    next_reg_rdata = reg_rdata;
    next_reg_ack = 1'b0;
    if (clk_en) begin
      if (reg_rd) begin
        next_reg_rdata = (reg_addr == clock_detector_pkg::STATUS_ADDR) ?
          status : clock_detector_pkg::STATUS_RESET;
        next_reg_ack = 1'b1;
      end else if (reg_wr) begin
        next_reg_ack = 1'b1; // see [RULE11]
      end
    end else begin
      next_reg_ack = reg_ack;
    end
  end

  // Status and port registers.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status <= clock_detector_pkg::STATUS_RESET;
      reg_rdata <= clock_detector_pkg::STATUS_RESET;
      reg_ack <= 1'b0;
    end else begin
      status <= next_status;
      reg_rdata <= next_reg_rdata;
      reg_ack <= next_reg_ack;
    end
  end

endmodule : clock_detector

// *** dv/audio_source.sv ***
`timescale 1ns/10ps
module audio_source (
  input wire logic link_run,
  input wire logic master_run,
  input wire logic [12:0] bits,
  input wire logic [12:0] low_len,
  output logic clk_link,
  output logic frame_sync_clock,
  output logic master_clock
);
  logic [12:0] pos;

  // Bit clock of 80 ns that stands still low while the source is idle.
  initial begin
    clk_link = 1'b0;
    #13;
    forever begin
      #40;
      clk_link = link_run ? ~clk_link : 1'b0;
    end
  end

  // Master clock of 160 ns, so a frame of N bit clocks sees N/2 edges.
  initial begin
    master_clock = 1'b0;
    forever begin
      #80;
      master_clock = master_run ? ~master_clock : 1'b0;
    end
  end

  // Start values, so the frame counter is never unknown before a stop.
  initial begin
    pos = 13'h0000;
    frame_sync_clock = 1'b0;
  end

  // Frame clock rises at a frame start and is low for the last low_len
  // bit clocks; an idle source leaves it tied low like a missing clock.
  always @(posedge clk_link or negedge link_run) begin
    if (!link_run) begin
      pos <= 13'h0000;
      frame_sync_clock <= 1'b0;
    end else begin
      pos <= (pos + 13'h0001 >= bits) ? 13'h0000 : pos + 13'h0001;
      frame_sync_clock <= (pos + 13'h0001 >= bits) ||
                          (pos + 13'h0001 < bits - low_len);
    end
  end
endmodule : audio_source

// *** dv/clock_detector_chk.sv ***
`timescale 1ns/10ps
module clock_detector_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic clk_link,
  input wire logic frame_sync_clock,
  input wire logic master_clock,
  input wire logic pll_enable,
  input wire logic pll_lock,
  input wire logic error_ignore_config,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack
);
  logic [2:0] mq;
  logic [6:0] m_age;

  // Age of the last master edge; it saturates so a halt never looks live.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mq <= 3'h0;
      m_age <= 7'h7f;
    end else begin
      mq <= {mq[1:0], master_clock};
      m_age <= (mq[2] != mq[1]) ? 7'h00 : m_age + {6'h00, m_age != 7'h7f};
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Reads taken at this edge, of the status register or elsewhere.
  sequence status_rd;
    clk_en && reg_rd && reg_addr == clock_detector_pkg::STATUS_ADDR;
  endsequence
  sequence other_rd;
    clk_en && reg_rd && reg_addr != clock_detector_pkg::STATUS_ADDR;
  endsequence

  ack_next_a:
    assert property (clk_en && (reg_rd || reg_wr) ##1 clk_en |-> reg_ack)
    else $error("request not answered");
  top_bit_a:
    assert property (reg_ack |-> !reg_rdata[7])
    else $error("bit 7 not zero");
  unmapped_read_a:
    assert property (other_rd |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  write_inert_a:
    assert property (clk_en && reg_wr && !reg_rd |=> $stable(reg_rdata))
    else $error("write changed read data");
  pll_off_a:
    assert property ((!pll_enable) [*4] ##0 status_rd |=> !reg_rdata[5])
    else $error("disabled pll shown locked");
  ignore_rate_a:
    assert property (error_ignore_config [*3] ##0 status_rd
                     |=> !reg_rdata[0])
    else $error("ignored rate error shown");
  mclk_live_a:
    assert property (status_rd ##0 $past(m_age, 16) < 7'h40
                     |=> !reg_rdata[6])
    else $error("live master clock shown missing");
  halt_bad_a:
    assert property (reg_ack && reg_rdata[6] |-> reg_rdata[2])
    else $error("halted master clock not invalid");
endmodule : clock_detector_chk

bind clock_detector clock_detector_chk clock_detector_chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en), .clk_link(clk_link),
  .frame_sync_clock(frame_sync_clock), .master_clock(master_clock),
  .pll_enable(pll_enable), .pll_lock(pll_lock),
  .error_ignore_config(error_ignore_config), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .reg_ack(reg_ack)
);

// *** dv/clock_detector_bench.sv ***
`timescale 1ns/10ps
module clock_detector_bench;
  logic clk_sys, rst_n, clk_en, pll_enable, pll_lock, error_ignore_config;
  logic reg_rd, reg_wr, reg_ack, link_run, master_run, clk_link, fsync, mclk;
  logic [7:0] reg_addr, reg_rdata, rd;
  logic [12:0] bits, low_len;
  int num_errors = 0;
  int num_checks = 0;

  audio_source audio_source_i (.link_run(link_run), .master_run(master_run),
    .bits(bits), .low_len(low_len), .clk_link(clk_link),
    .frame_sync_clock(fsync), .master_clock(mclk));
  clock_detector clock_detector_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .clk_link(clk_link), .frame_sync_clock(fsync),
    .master_clock(mclk), .pll_enable(pll_enable), .pll_lock(pll_lock),
    .error_ignore_config(error_ignore_config), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack));

  // Inputs move 2 ns after the edge so the design never races the bench.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  // One strobe; the answer stands only in the cycle after the taking edge.
  task automatic read(input logic [7:0] addr);
    reg_addr = addr;
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    chk({7'h00, reg_ack}, 8'h01);
    rd = reg_rdata;
    tick(1);
    chk({7'h00, reg_ack}, 8'h00);
  endtask : read

  // Lets the source settle, then compares the masked status.
  task automatic status(input int n, input logic [7:0] mask,
                        input logic [7:0] exp);
    tick(n);
    read(clock_detector_pkg::STATUS_ADDR);
    chk(rd & mask, exp);
  endtask : status

  // Status first, since the freeze below may spoil the frame in flight;
  // then a frozen port, a write and an unmapped read.
  task automatic t_port;
    status(1, 8'hff, 8'h20);
    clk_en = 1'b0;
    reg_rd = 1'b1;
    tick(1);
    chk({7'h00, reg_ack}, 8'h00);
    reg_rd = 1'b0;
    clk_en = 1'b1;
    tick(1);
    chk({7'h00, reg_ack}, 8'h00);
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    chk({7'h00, reg_ack}, 8'h01);
    chk(reg_rdata, rd);
    tick(1);
    chk({7'h00, reg_ack}, 8'h00);
    read(8'h12);
    chk(rd, 8'h00);
  endtask : t_port

  // Lock follows the enable as well as the lock input. The first wait
  // covers three frames, so a frame cut by the freeze has passed.
  task automatic t_pll;
    pll_lock = 1'b0;
    status(800, 8'hff, 8'h00);
    pll_enable = 1'b0;
    pll_lock = 1'b1;
    status(10, 8'hff, 8'h08);
    pll_enable = 1'b1;
    status(10, 8'hff, 8'h20);
  endtask : t_pll

  // Frame low length and bits per frame at their limits.
  task automatic t_frame;
    low_len = 13'h0006;
    status(1000, 8'hff, 8'h20);
    low_len = 13'h0005;
    status(1000, 8'hff, 8'h24);
    low_len = 13'h0040;
    bits = 13'h0100;
    status(2000, 8'hff, 8'h20);
    bits = 13'h012c;
    status(2000, 8'hff, 8'h2e);
    bits = 13'h0080;
    status(2000, 8'hff, 8'h20);
  endtask : t_frame

  // A halted master clock and its return.
  task automatic t_mclk;
    master_run = 1'b0;
    status(3000, 8'hff, 8'h6c);
    master_run = 1'b1;
    status(2000, 8'hff, 8'h20);
  endtask : t_mclk

  // Both link clocks gone, then the rate error hidden by the setting.
  task automatic t_link;
    link_run = 1'b0;
    status(3000, 8'h9b, 8'h1b);
    error_ignore_config = 1'b1;
    status(10, 8'h9b, 8'h1a);
    link_run = 1'b1;
    status(2000, 8'hff, 8'h20);
    error_ignore_config = 1'b0;
  endtask : t_link

  task automatic end_sim;
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // System clock of 40 ns.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Watchdog, about three times the length of the planned run.
  initial begin
    #(60000 * 40);
    num_errors++;
    end_sim();
  end

  // Reset, then every scenario in turn.
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    pll_enable = 1'b1;
    pll_lock = 1'b1;
    error_ignore_config = 1'b0;
    reg_addr = 8'h5e;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    link_run = 1'b1;
    master_run = 1'b1;
    bits = 13'h0080;
    low_len = 13'h0040;
    tick(8);
    chk(reg_rdata, clock_detector_pkg::STATUS_RESET);
    rst_n = 1'b1;
    tick(3000);
    t_port();
    t_pll();
    t_frame();
    t_mclk();
    t_link();
    end_sim();
  end
endmodule : clock_detector_bench
